/* verilog/apes_pkg.sv */
package apes_pkg;

    // Command codes seen on the command port
    localparam logic [7:0] CMD_SET_LOGICAL   = 8'h09;
    localparam logic [7:0] CMD_SET_REAL      = 8'h0a;
    localparam logic [7:0] CMD_SET_CMP_PLUS  = 8'h0b;
    localparam logic [7:0] CMD_SET_CMP_MINUS = 8'h0c;
    localparam logic [7:0] CMD_SET_ACC_OFS   = 8'h0d;
    localparam logic [7:0] CMD_SET_DEC_RATE  = 8'h0e;
    localparam logic [7:0] CMD_SET_EXT_MODE  = 8'h60;
    localparam logic [7:0] CMD_RD_LOGICAL    = 8'h10;
    localparam logic [7:0] CMD_RD_REAL       = 8'h11;

    // Bit positions in extension_mode_low
    localparam int EXT_ENC_CLEAR   = 0;
    localparam int EXT_ENC_INVERT  = 1;
    localparam int EXT_PULSE_SWAP  = 2;
    localparam int EXT_TRI_PREVENT = 3;
    localparam int EXT_VAR_RING    = 4;
    localparam int EXT_HOME_IRQ    = 5;
    localparam int EXT_SPD_PRIO    = 7;

    // Bit position of the home-done flag in the interrupt status word
    localparam int IRQ_HOME_DONE_BIT = 8;

    // Reset values and counter step
    localparam logic [15:0] ACC_OFS_RESET  = 16'h0008;
    localparam logic [15:0] DEC_RATE_RESET = 16'h0001;
    localparam logic [15:0] EXT_RESET      = 16'h0000;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;
    localparam logic [31:0] POS_RESET      = 32'h0000_0000;
    localparam logic [31:0] POS_STEP       = 32'h0000_0001;

    // Decel increasing rate = DRATE_BASE / value * DRATE_REF / range
    localparam int unsigned DRATE_BASE = 62_500_000;
    localparam int unsigned DRATE_REF  = 8_000_000;

    // Pin synchroniser lanes
    localparam int SYNC_W   = 3;
    localparam int PIN_A    = 0;
    localparam int PIN_B    = 1;
    localparam int PIN_STOP = 2;

    typedef enum logic [1:0] {
        IRQ_IDLE   = 2'b01,
        IRQ_ACTIVE = 2'b10
    } apes_irq_state_t;

endpackage

/* verilog/apes_pos_counter.sv */
`timescale 1ns/1ps
module apes_pos_counter (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    input  wire logic        clear,
    input  wire logic        count_en,
    input  wire logic        count_up,
    input  wire logic        ring_en,
    input  wire logic [31:0] ring_max,
    // Count
    output logic      [31:0] value
);

    // Load beats clear beats count, so a preset is never lost to a pulse
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= apes_pkg::POS_RESET;
        end else if (load) begin
            value <= load_value;
        end else if (clear) begin
            value <= apes_pkg::POS_RESET;
        end else if (count_en) begin
            if (count_up) begin
                if (ring_en && value == ring_max) begin
                    value <= apes_pkg::POS_RESET; // [RULE_18]
                end else begin
                    value <= value + apes_pkg::POS_STEP;
                end
            end else begin
                if (ring_en && value == apes_pkg::POS_RESET) begin
                    value <= ring_max; // [RULE_18]
                end else begin
                    value <= value - apes_pkg::POS_STEP;
                end
            end
        end
    end

endmodule

/* verilog/apes_axis_setup.sv */
// Operation
// RULE_01 - Command 09h presets the logical counter with the 32-bit data word.
// RULE_02 - Logical counter counts up on plus drive pulses, down on minus ones.
// RULE_03 - Logical counter is writable and readable at any moment, even driving.
// RULE_04 - Command 0Ah presets the real counter; writable and readable any time.
// RULE_05 - Real counter follows encoder pulse input, not drive pulses.
// RULE_06 - Command 0Bh loads compare-plus; compare result to status and output.
// RULE_07 - Command 0Ch loads compare-minus; compare result to status and output.
// RULE_08 - Command 0Dh sets signed acceleration counter offset; reset value is 8.
// RULE_09 - Host should set offset zero before low-speed fixed pulse acceleration.
// RULE_10 - Command 0Eh stores the 16-bit deceleration increasing rate value.
// RULE_11 - Rate equals 62.5e6 over value times 8,000,000 over range.
// RULE_12 - Host loads both data words, then 60h copies them into extension mode.
// RULE_13 - Reset clears both extension mode words.
// RULE_14 - Encoder clear bit: active stop input stops drive and clears real counter.
// RULE_15 - Encoder invert bit reverses real counter direction in both input modes.
// RULE_16 - Pulse swap bit routes plus pulses to minus pin and back.
// RULE_17 - Triangle prevention bit enables it in trapezoidal fixed pulse driving.
// RULE_18 - Variable ring bit enables ring counting on both position counters.
// RULE_19 - Home irq bit: home search end pulls interrupt low, sets home-done flag.
// RULE_20 - Reading interrupt status clears its bits and releases the interrupt.
// RULE_21 - Speed priority bit makes S-curve favour reaching the drive speed.
// RULE_22 - Data read command places the value into both data read words.
// RULE_23 - 4-byte data takes low half from low word, high half from high word.
`timescale 1ns/1ps
module apes_axis_setup (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Host command and data port
    input  wire logic        command_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_axis_sel,
    input  wire logic [15:0] data_write_low,
    input  wire logic [15:0] data_write_high,
    input  wire logic        irq_status_read,
    output logic      [15:0] data_read_low,
    output logic      [15:0] data_read_high,
    output logic      [15:0] irq_status_data,
    // Drive engine side
    input  wire logic        drive_pulse,
    input  wire logic        drive_dir_plus,
    input  wire logic        home_search_done,
    input  wire logic        cmp_src_real,
    input  wire logic        enc_mode_updown,
    input  wire logic        stop_two_enable,
    input  wire logic        stop_two_level,
    output logic             stop_drive_req,
    output logic      [15:0] accel_counter_offset,
    output logic      [15:0] decel_rate_value,
    output logic      [15:0] extension_mode_low,
    output logic      [15:0] extension_mode_high,
    output logic      [31:0] logical_position_counter,
    output logic      [31:0] real_position_counter,
    // Status
    output logic             cmp_plus_status,
    output logic             cmp_minus_status,
    output logic             home_done_flag,
    // Pins
    input  wire logic        plus_pulse_in,
    input  wire logic        minus_pulse_in,
    input  wire logic        stop_input_two,
    output logic             plus_pulse_out_n,
    output logic             minus_pulse_out_n,
    output logic             compare_plus_out,
    output logic             compare_minus_out,
    output logic             interrupt_out_n,
    output logic             interrupt_out_oe
);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    localparam int SYNC_W_L = apes_pkg::SYNC_W;
    typedef apes_pkg::apes_irq_state_t apes_irq_loc_t;

    logic [31:0]             compare_plus_value;
    logic [31:0]             compare_minus_value;
    logic [31:0]             data_word;
    logic [31:0]             cmp_source;
    logic [SYNC_W_L-1:0]     sync_meta;
    logic [SYNC_W_L-1:0]     sync_pin;
    logic                    enc_a_prev;
    logic                    enc_b_prev;
    logic                    stop_prev_act;
    logic                    stop_act;
    logic                    stop_clear;
    logic                    enc_step;
    logic                    enc_up_raw;
    logic                    enc_up;
    logic                    plus_sel;
    logic                    ld_logical;
    logic                    ld_real;
    apes_irq_loc_t           irq_state;
    apes_irq_loc_t           next_irq_state;

    // One decode serves every command code for this axis
    function automatic logic cmd_hit(input logic [7:0] code);
        cmd_hit = command_write && cmd_axis_sel && cmd_code == code;
    endfunction

    // Four-byte parameters are assembled when the command arrives
    assign data_word  = {data_write_high, data_write_low}; // [RULE_23]
    assign ld_logical = cmd_hit(apes_pkg::CMD_SET_LOGICAL); // [RULE_01] [RULE_03]
    assign ld_real    = cmd_hit(apes_pkg::CMD_SET_REAL); // [RULE_04]

    // Pin synchronisers; only the second stage feeds logic
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W_L; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_meta[gi] <= 1'b0;
                    sync_pin[gi]  <= 1'b0;
                end else begin
                    sync_meta[gi] <= gi == apes_pkg::PIN_A    ? plus_pulse_in :
                                     gi == apes_pkg::PIN_B    ? minus_pulse_in :
                                                                stop_input_two;
                    sync_pin[gi]  <= sync_meta[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_a_prev    <= 1'b0;
            enc_b_prev    <= 1'b0;
            stop_prev_act <= 1'b0;
        end else begin
            enc_a_prev    <= sync_pin[apes_pkg::PIN_A];
            enc_b_prev    <= sync_pin[apes_pkg::PIN_B];
            stop_prev_act <= stop_act;
        end
    end

    // Encoder decode: quadrature steps on single-phase change, up/down on rising edges
    always_comb begin
        if (enc_mode_updown) begin
            enc_step   = (sync_pin[apes_pkg::PIN_A] && !enc_a_prev) ^
                         (sync_pin[apes_pkg::PIN_B] && !enc_b_prev);
            enc_up_raw = sync_pin[apes_pkg::PIN_A] && !enc_a_prev;
        end else begin
            enc_step   = (sync_pin[apes_pkg::PIN_A] ^ enc_a_prev) ^
                         (sync_pin[apes_pkg::PIN_B] ^ enc_b_prev);
            enc_up_raw = sync_pin[apes_pkg::PIN_A] ^ enc_b_prev;
        end
    end

    assign enc_up = enc_up_raw ^ extension_mode_low[apes_pkg::EXT_ENC_INVERT]; // [RULE_15]

    // Stop input acts on its edge into the active level only
    assign stop_act   = stop_two_enable && (sync_pin[apes_pkg::PIN_STOP] == stop_two_level);
    assign stop_clear = extension_mode_low[apes_pkg::EXT_ENC_CLEAR] && stop_act && !stop_prev_act; // [RULE_14]

    apes_pos_counter u_logical (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .load       (ld_logical),
        .load_value (data_word),
        .clear      (1'b0),
        .count_en   (drive_pulse), // [RULE_02]
        .count_up   (drive_dir_plus),
        .ring_en    (extension_mode_low[apes_pkg::EXT_VAR_RING]), // [RULE_18]
        .ring_max   (compare_plus_value),
        .value      (logical_position_counter)
    );

    apes_pos_counter u_real (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .load       (ld_real),
        .load_value (data_word),
        .clear      (stop_clear), // [RULE_14]
        .count_en   (enc_step), // [RULE_05]
        .count_up   (enc_up),
        .ring_en    (extension_mode_low[apes_pkg::EXT_VAR_RING]), // [RULE_18]
        .ring_max   (compare_plus_value),
        .value      (real_position_counter)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_drive_req <= 1'b0;
        end else begin
            stop_drive_req <= stop_clear; // [RULE_14]
        end
    end

    // Parameter registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_plus_value   <= apes_pkg::POS_RESET;
            compare_minus_value  <= apes_pkg::POS_RESET;
            accel_counter_offset <= apes_pkg::ACC_OFS_RESET; // [RULE_08]
            decel_rate_value     <= apes_pkg::DEC_RATE_RESET;
        end else begin
            if (cmd_hit(apes_pkg::CMD_SET_CMP_PLUS)) begin
                compare_plus_value <= data_word; // [RULE_06]
            end
            if (cmd_hit(apes_pkg::CMD_SET_CMP_MINUS)) begin
                compare_minus_value <= data_word; // [RULE_07]
            end
            // Only the low half carries the signed offset
            if (cmd_hit(apes_pkg::CMD_SET_ACC_OFS)) begin
                accel_counter_offset <= data_write_low; // [RULE_08]
            end
            // Zero is outside the range; the old value is kept to avoid a divide by zero
            if (cmd_hit(apes_pkg::CMD_SET_DEC_RATE) && data_write_low != apes_pkg::WORD_ZERO) begin
                decel_rate_value <= data_write_low; // [RULE_10] [RULE_11]
            end
        end
    end

    // Extension mode words
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            extension_mode_low  <= apes_pkg::EXT_RESET; // [RULE_13]
            extension_mode_high <= apes_pkg::EXT_RESET; // [RULE_13]
        end else if (cmd_hit(apes_pkg::CMD_SET_EXT_MODE)) begin
            extension_mode_low  <= data_write_low; // [RULE_12]
            extension_mode_high <= data_write_high; // [RULE_12]
        end
    end

    // Triangle prevention and speed priority bits are consumed by the drive engine
    // through extension_mode_low [RULE_17] [RULE_21]

    // Comparators; signed so that negative positions order correctly
    assign cmp_source = cmp_src_real ? real_position_counter : logical_position_counter;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_plus_status   <= 1'b0;
            cmp_minus_status  <= 1'b0;
            compare_plus_out  <= 1'b0;
            compare_minus_out <= 1'b0;
        end else begin
            cmp_plus_status   <= $signed(cmp_source) >= $signed(compare_plus_value); // [RULE_06]
            cmp_minus_status  <= $signed(cmp_source) < $signed(compare_minus_value); // [RULE_07]
            compare_plus_out  <= $signed(cmp_source) >= $signed(compare_plus_value); // [RULE_06]
            compare_minus_out <= $signed(cmp_source) < $signed(compare_minus_value); // [RULE_07]
        end
    end

    // Drive pulse pins, active low
    assign plus_sel = drive_dir_plus ^ extension_mode_low[apes_pkg::EXT_PULSE_SWAP]; // [RULE_16]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            plus_pulse_out_n  <= 1'b1;
            minus_pulse_out_n <= 1'b1;
        end else begin
            plus_pulse_out_n  <= !(drive_pulse && plus_sel); // [RULE_16]
            minus_pulse_out_n <= !(drive_pulse && !plus_sel); // [RULE_16]
        end
    end

    // Data read words; a set command on the same cycle is shown one read later
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_read_low  <= apes_pkg::WORD_ZERO;
            data_read_high <= apes_pkg::WORD_ZERO;
        end else if (cmd_hit(apes_pkg::CMD_RD_LOGICAL)) begin
            data_read_low  <= logical_position_counter[15:0]; // [RULE_22] [RULE_03]
            data_read_high <= logical_position_counter[31:16];
        end else if (cmd_hit(apes_pkg::CMD_RD_REAL)) begin
            data_read_low  <= real_position_counter[15:0]; // [RULE_22] [RULE_04]
            data_read_high <= real_position_counter[31:16];
        end
    end

    // Home-done interrupt; a new event in the read cycle wins over the clear
    always_comb begin
        case (irq_state)
            apes_pkg::IRQ_IDLE: begin
                if (home_search_done && extension_mode_low[apes_pkg::EXT_HOME_IRQ]) begin
                    next_irq_state = apes_pkg::IRQ_ACTIVE; // [RULE_19]
                end else begin
                    next_irq_state = apes_pkg::IRQ_IDLE;
                end
            end
            apes_pkg::IRQ_ACTIVE: begin
                if (irq_status_read && !home_search_done) begin
                    next_irq_state = apes_pkg::IRQ_IDLE; // [RULE_20]
                end else begin
                    next_irq_state = apes_pkg::IRQ_ACTIVE;
                end
            end
            default: begin
                next_irq_state = apes_pkg::IRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_state        <= apes_pkg::IRQ_IDLE;
            home_done_flag   <= 1'b0;
            interrupt_out_oe <= 1'b0;
            interrupt_out_n  <= 1'b0;
            irq_status_data  <= apes_pkg::WORD_ZERO;
        end else begin
            irq_state        <= next_irq_state;
            home_done_flag   <= next_irq_state == apes_pkg::IRQ_ACTIVE; // [RULE_19] [RULE_20]
            interrupt_out_oe <= next_irq_state == apes_pkg::IRQ_ACTIVE; // [RULE_19] [RULE_20]
            interrupt_out_n  <= 1'b0;
            irq_status_data  <= apes_pkg::WORD_ZERO;
            irq_status_data[apes_pkg::IRQ_HOME_DONE_BIT] <= next_irq_state == apes_pkg::IRQ_ACTIVE;
        end
    end

    // Checks
    lp_preset_a: assert property (ld_logical |=> logical_position_counter == $past(data_word)) // [RULE_01]
        else $error("Logical counter preset missed");
    lp_count_a: assert property (drive_pulse && drive_dir_plus && !ld_logical
        && !extension_mode_low[apes_pkg::EXT_VAR_RING]
        |=> logical_position_counter == $past(logical_position_counter) + apes_pkg::POS_STEP) // [RULE_02]
        else $error("Logical counter did not count up");
    ep_preset_a: assert property (ld_real |=> real_position_counter == $past(data_word)) // [RULE_04]
        else $error("Real counter preset missed");
    ep_hold_a: assert property (!enc_step && !ld_real && !stop_clear
        |=> $stable(real_position_counter)) // [RULE_05]
        else $error("Real counter moved without encoder input");
    stop_clear_a: assert property (stop_clear && !ld_real
        |=> real_position_counter == apes_pkg::POS_RESET && stop_drive_req) // [RULE_14]
        else $error("Stop input did not clear real counter");
    cmp_plus_a: assert property ($past(rst_n) |-> cmp_plus_status ==
        ($signed($past(cmp_source)) >= $signed($past(compare_plus_value))) && compare_plus_out == cmp_plus_status) // [RULE_06]
        else $error("Compare plus result wrong");
    cmp_minus_a: assert property ($past(rst_n) |-> cmp_minus_status ==
        ($signed($past(cmp_source)) < $signed($past(compare_minus_value))) && compare_minus_out == cmp_minus_status) // [RULE_07]
        else $error("Compare minus result wrong");
    ext_load_a: assert property (cmd_hit(apes_pkg::CMD_SET_EXT_MODE)
        |=> extension_mode_low == $past(data_write_low) && extension_mode_high == $past(data_write_high)) // [RULE_12]
        else $error("Extension mode not loaded");
    pulse_swap_a: assert property (drive_pulse && drive_dir_plus && extension_mode_low[apes_pkg::EXT_PULSE_SWAP]
        |=> !minus_pulse_out_n && plus_pulse_out_n) // [RULE_16]
        else $error("Swapped plus pulse on wrong pin");
    irq_raise_a: assert property (home_search_done && extension_mode_low[apes_pkg::EXT_HOME_IRQ]
        |=> interrupt_out_oe && home_done_flag && !interrupt_out_n) // [RULE_19]
        else $error("Home end did not raise interrupt");
    irq_clear_a: assert property (interrupt_out_oe && irq_status_read && !home_search_done
        |=> !interrupt_out_oe && !home_done_flag && irq_status_data == apes_pkg::WORD_ZERO) // [RULE_20]
        else $error("Status read did not release interrupt");
    rd_lp_a: assert property (cmd_hit(apes_pkg::CMD_RD_LOGICAL)
        |=> {data_read_high, data_read_low} == $past(logical_position_counter)) // [RULE_22]
        else $error("Logical counter read wrong");
    acc_ofs_a: assert property (cmd_hit(apes_pkg::CMD_SET_ACC_OFS)
        |=> accel_counter_offset == $past(data_write_low)) // [RULE_08]
        else $error("Acceleration offset not loaded");

endmodule

/* tb/apes_host_model.sv */
`timescale 1ns/1ps
module apes_host_model (
    // Clock
    input  wire logic        ref_clk,
    // Command port
    output logic             command_write,
    output logic [7:0]       cmd_code,
    output logic             cmd_axis_sel,
    output logic [15:0]      data_write_low,
    output logic [15:0]      data_write_high,
    output logic             irq_status_read
);
    initial begin
        command_write = 1'b0;
        cmd_code = 8'h00;
        cmd_axis_sel = 1'b0;
        {data_write_high, data_write_low} = 32'h0000_0000;
        irq_status_read = 1'b0;
    end
    // Both words stand with the strobe
    task automatic send(input logic [7:0] code, input logic [31:0] val, input logic sel);
        @(posedge ref_clk);
        command_write <= 1'b1;
        cmd_code <= code;
        cmd_axis_sel <= sel;
        {data_write_high, data_write_low} <= val;
        @(posedge ref_clk);
        command_write <= 1'b0;
        // Released words carry junk so stale data cannot pass
        {data_write_high, data_write_low} <= ~val;
    endtask
    task automatic read_irq();
        @(posedge ref_clk);
        irq_status_read <= 1'b1;
        @(posedge ref_clk);
        irq_status_read <= 1'b0;
    endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic command_write, cmd_axis_sel, irq_status_read;
    logic [7:0] cmd_code;
    logic [15:0] data_write_low, data_write_high, data_read_low, data_read_high, irq_status_data;
    logic drive_pulse = 1'b0, drive_dir_plus = 1'b0, home_search_done = 1'b0, cmp_src_real = 1'b0;
    logic enc_mode_updown = 1'b1, stop_two_enable = 1'b1, stop_two_level = 1'b1;
    logic plus_pulse_in = 1'b0, minus_pulse_in = 1'b0, stop_input_two = 1'b0;
    logic [15:0] accel_counter_offset, decel_rate_value, extension_mode_low, extension_mode_high;
    logic [31:0] logical_position_counter, real_position_counter;
    logic stop_drive_req, cmp_plus_status, cmp_minus_status, home_done_flag;
    logic plus_pulse_out_n, minus_pulse_out_n, compare_plus_out, compare_minus_out;
    logic interrupt_out_n, interrupt_out_oe;
    logic saw_stop = 1'b0;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    typedef struct { logic [7:0] code; logic [31:0] val; int sel; logic [31:0] exp; } apes_row_t;
    apes_row_t rows[8] = '{'{8'h09, 32'h0001_0002, 0, 32'h0001_0002},
        '{8'h0a, 32'h8000_0001, 1, 32'h8000_0001}, '{8'h0d, 32'h1234_8000, 2, 32'h0000_8000},
        '{8'h0e, 32'h0000_ffff, 3, 32'h0000_ffff}, '{8'h0e, 32'h0000_0000, 3, 32'h0000_ffff},
        '{8'h60, 32'h5a5a_0088, 4, 32'h5a5a_0088}, '{8'h10, 32'h0000_0000, 5, 32'h0001_0002},
        '{8'h11, 32'h0000_0000, 5, 32'h8000_0001}};
    apes_host_model apes_host_model_inst (.ref_clk, .command_write, .cmd_code, .cmd_axis_sel,
        .data_write_low, .data_write_high, .irq_status_read);
    apes_axis_setup apes_axis_setup_inst (.ref_clk, .rst_n, .command_write, .cmd_code, .cmd_axis_sel,
        .data_write_low, .data_write_high, .irq_status_read, .data_read_low, .data_read_high,
        .irq_status_data, .drive_pulse, .drive_dir_plus, .home_search_done, .cmp_src_real,
        .enc_mode_updown, .stop_two_enable, .stop_two_level, .stop_drive_req, .accel_counter_offset,
        .decel_rate_value, .extension_mode_low, .extension_mode_high, .logical_position_counter,
        .real_position_counter, .cmp_plus_status, .cmp_minus_status, .home_done_flag, .plus_pulse_in,
        .minus_pulse_in, .stop_input_two, .plus_pulse_out_n, .minus_pulse_out_n, .compare_plus_out,
        .compare_minus_out, .interrupt_out_n, .interrupt_out_oe);
    always #50 ref_clk = ~ref_clk;
    task automatic end_sim();
        $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [31:0] pick(input int sel);
        case (sel)
            0: return logical_position_counter;
            1: return real_position_counter;
            2: return {16'h0000, accel_counter_offset};
            3: return {16'h0000, decel_rate_value};
            4: return {extension_mode_high, extension_mode_low};
            default: return {data_read_high, data_read_low};
        endcase
    endfunction
    task automatic drive(input logic dir);
        @(posedge ref_clk);
        drive_pulse <= 1'b1;
        drive_dir_plus <= dir;
        @(posedge ref_clk);
        drive_pulse <= 1'b0;
        @(negedge ref_clk);
    endtask
    // Pins pass two sync flops, so hold each level well past that
    task automatic enc(input logic plus);
        @(posedge ref_clk);
        {plus_pulse_in, minus_pulse_in} <= {plus, !plus};
        repeat (5) @(posedge ref_clk);
        {plus_pulse_in, minus_pulse_in} <= 2'b00;
        repeat (5) @(negedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (stop_drive_req === 1'b1)
            saw_stop <= 1'b1;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check("offset", pick(2), 32'h0000_0008);
        check("ext", pick(4), 32'h0000_0000);
        foreach (rows[i]) begin
            apes_host_model_inst.send(rows[i].code, rows[i].val, 1'b1);
            @(negedge ref_clk);
            check("row", pick(rows[i].sel), rows[i].exp);
        end
        apes_host_model_inst.send(8'h09, 32'h0000_0007, 1'b0);
        @(negedge ref_clk);
        check("unselected", pick(0), 32'h0001_0002);
        apes_host_model_inst.send(8'h60, 32'h0000_0004, 1'b1);
        apes_host_model_inst.send(8'h0d, 32'h0000_0000, 1'b1);
        @(negedge ref_clk);
        check("offset0", pick(2), 32'h0000_0000);
        drive(1'b1);
        check("lp_up", pick(0), 32'h0001_0003);
        check("swap_plus", {30'h0, plus_pulse_out_n, minus_pulse_out_n}, 32'h2);
        drive(1'b0);
        check("lp_down", pick(0), 32'h0001_0002);
        check("swap_minus", {30'h0, plus_pulse_out_n, minus_pulse_out_n}, 32'h1);
        enc(1'b0);
        check("ep_down", pick(1), 32'h8000_0000);
        apes_host_model_inst.send(8'h60, 32'h0000_0002, 1'b1);
        enc(1'b0);
        check("ep_inv", pick(1), 32'h8000_0001);
        apes_host_model_inst.send(8'h0b, 32'h0001_0002, 1'b1);
        apes_host_model_inst.send(8'h0c, 32'h0001_0003, 1'b1);
        repeat (2) @(negedge ref_clk);
        check("cmp", {28'h0, cmp_plus_status, compare_plus_out, cmp_minus_status, compare_minus_out}, 32'hf);
        apes_host_model_inst.send(8'h0c, 32'h0001_0002, 1'b1);
        repeat (2) @(negedge ref_clk);
        check("cmp_m", {28'h0, cmp_plus_status, compare_plus_out, cmp_minus_status, compare_minus_out}, 32'hc);
        cmp_src_real <= 1'b1;
        repeat (2) @(negedge ref_clk);
        check("cmp_ep", {28'h0, cmp_plus_status, compare_plus_out, cmp_minus_status, compare_minus_out}, 32'h3);
        apes_host_model_inst.send(8'h60, 32'h0000_0010, 1'b1);
        drive(1'b1);
        check("ring_wrap", pick(0), 32'h0000_0000);
        apes_host_model_inst.send(8'h60, 32'h0000_0021, 1'b1);
        @(posedge ref_clk);
        stop_input_two <= 1'b1;
        repeat (6) @(negedge ref_clk);
        check("ep_clr", pick(1), 32'h0000_0000);
        check("stop_req", {31'h0, saw_stop}, 32'h0000_0001);
        @(posedge ref_clk);
        home_search_done <= 1'b1;
        @(posedge ref_clk);
        home_search_done <= 1'b0;
        @(negedge ref_clk);
        check("irq", {interrupt_out_oe, interrupt_out_n, home_done_flag, irq_status_data}, 32'h5_0100);
        apes_host_model_inst.read_irq();
        @(negedge ref_clk);
        check("irq_clr", {interrupt_out_oe, home_done_flag, irq_status_data}, 32'h0);
        end_sim();
    end
endmodule
